// >>> common/rstsup_pkg.sv
// Purpose: Shared constants for the reset supervisor and low voltage detector
// Assumes: 25 MHz system clock, AXI4-Lite with 32-bit data and address
// Notes:   Register addresses are byte addresses
package rstsup_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          STRETCH_NS    = 20000;
  localparam int          STRETCH_CYC   = (STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CNT_W         = 10;
  localparam logic [9:0]  STRETCH_LOAD  = STRETCH_CYC[9:0];
  localparam int          PIN_HOLDOFF   = 4;

  // ==========================================================================
  // Register addresses
  localparam logic [31:0] ADDR_RSC      = 32'h4002_1024;
  localparam logic [31:0] ADDR_PCTL0    = 32'h4000_7000;
  localparam logic [31:0] ADDR_PSTAT    = 32'h4000_7004;
  localparam logic [31:0] ADDR_IRQ_STAT = 32'h4000_7008;
  localparam logic [31:0] ADDR_IRQ_EN   = 32'h4000_700C;
  localparam logic [31:0] ADDR_IRQ_CLR  = 32'h4000_7010;

  // ==========================================================================
  // Field positions of reset_source_and_lowspeed_rc
  localparam int BIT_LP_FLAG  = 31;
  localparam int BIT_WDT_FLAG = 29;
  localparam int BIT_SW_FLAG  = 28;
  localparam int BIT_PWR_FLAG = 27;
  localparam int BIT_PIN_FLAG = 26;
  localparam int BIT_BOR_FLAG = 25;
  localparam int BIT_FLAG_CLR = 24;
  localparam int BIT_RC_STB   = 1;
  localparam int BIT_RC_ON    = 0;

  // Fields of power_control0, power_control_status and interrupt registers
  localparam int BIT_LVT_LSB  = 0;
  localparam int BIT_LVD_ON   = 4;
  localparam int BIT_LVD_FLAG = 0;
  localparam int BIT_IRQ_RISE = 0;
  localparam int BIT_IRQ_FALL = 1;

  // ==========================================================================
  // Codes and reset values
  localparam logic [2:0]  LVT_EXT_PIN   = 3'h7;
  localparam logic [2:0]  LVT_RESET     = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          SYNC_W        = 23;
  localparam logic [22:0] SYNC_RESET    = 23'h40_0040;

endpackage : rstsup_pkg

// >>> design/rstsup_stretch.sv
// Purpose: Stretches a reset request into a low pulse of a minimum length
// Assumes: Request is synchronous to aclk
// Notes:   Output is low during and STRETCH_CYC cycles after the request
`timescale 1ns/1ns
module rstsup_stretch (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Request and stretched reset
  input  wire logic req,
  output logic      rst_n
);
  import rstsup_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // Reload while requested, then count down
  assign cnt_next = req ? STRETCH_LOAD :
                    (cnt_reg != '0) ? cnt_reg - 10'h001 : cnt_reg;

  // ==========================================================================
  // Counter and output flop, a full pulse also follows the bus reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= STRETCH_LOAD;
      rst_n   <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      rst_n   <= (cnt_next == '0);
    end
  end

endmodule : rstsup_stretch

// >>> design/rstsup_sync.sv
// Purpose: Two flip-flop synchroniser for a vector of asynchronous inputs
// Assumes: Bits are independent levels
// Notes:   The first stage feeds only the second stage
`timescale 1ns/1ns
module rstsup_sync #(
  parameter int               W       = 1,
  parameter logic [W-1:0]     RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // Per-bit double register
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_reg[i] <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

endmodule : rstsup_sync

// >>> design/rstsup_top.sv
// Purpose: Reset supervisor with sticky reset causes and low voltage detector
// Assumes: Analog comparators and option byte arrive as asynchronous levels
// Notes:   aresetn is the root (power-on) reset of this block
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ns
module rstsup_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Analog comparators and option byte
  input  wire logic        por_below,
  input  wire logic [4:0]  bor_above,
  input  wire logic [2:0]  brownout_threshold_code,
  input  wire logic [6:0]  lvd_above,
  input  wire logic        lvd_pin_above_ref,
  // Reset requests and oscillator status
  input  wire logic        watchdog_req,
  input  wire logic        software_req,
  input  wire logic        low_power_req,
  input  wire logic        backup_req,
  input  wire logic        slow_rc_stable,
  // External reset pin, open drain
  input  wire logic        external_reset_pin_n_in,
  output logic             external_reset_pin_n_out,
  output logic             external_reset_pin_n_oe_n,
  // Reset and status outputs
  output logic             power_reset_n,
  output logic             system_reset_n,
  output logic             backup_reset_n,
  output logic             external_interrupt_unit_line16,
  output logic             slow_rc_on,
  output logic             irq
);
  import rstsup_pkg::*;

  // ==========================================================================
  // Synchronised inputs
  logic [SYNC_W-1:0] async_vec;
  logic [SYNC_W-1:0] sync_vec;
  logic              por_s;
  logic [4:0]        bor_s;
  logic [2:0]        bcode_s;
  logic [6:0]        lvd_s;
  logic              lvd_pin_s;
  logic              pin_s;
  logic              wdt_s;
  logic              sw_s;
  logic              lp_s;
  logic              bkp_s;
  logic              stb_s;

  assign async_vec = {por_below, bor_above, brownout_threshold_code, lvd_above,
                      lvd_pin_above_ref, external_reset_pin_n_in, watchdog_req,
                      software_req, low_power_req, backup_req, slow_rc_stable};
  assign {por_s, bor_s, bcode_s, lvd_s, lvd_pin_s, pin_s, wdt_s, sw_s, lp_s,
          bkp_s, stb_s} = sync_vec;

  rstsup_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RESET)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (async_vec),
    .sync_out (sync_vec)
  );

  // ==========================================================================
  // Reset conditions
  logic       bor_ok;
  logic       bor_low;
  logic       power_cond;
  logic       pin_req;
  logic       sys_cond;
  logic       pwr_n;
  logic       sys_n;
  logic [PIN_HOLDOFF-1:0] drive_hist_reg;

  assign bor_ok = (bcode_s == 3'h4) ? bor_s[4] :
                  (bcode_s == 3'h3) ? bor_s[3] :
                  (bcode_s == 3'h2) ? bor_s[2] :
                  (bcode_s == 3'h1) ? bor_s[1] : bor_s[0];
  assign bor_low = ~bor_ok & ~por_s;
  assign power_cond = por_s | ~bor_ok;
  // Ignore our own drive until the pin has had time to rise again
  assign pin_req  = ~pin_s & sys_n & ~(|drive_hist_reg);
  assign sys_cond = power_cond | pin_req | wdt_s | sw_s | lp_s;

  rstsup_stretch u_pwr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (power_cond),
    .rst_n   (pwr_n)
  );

  rstsup_stretch u_sys (
    .aclk    (aclk),
    .aresetn (aresetn),
    .req     (sys_cond),
    .rst_n   (sys_n)
  );

  assign power_reset_n  = pwr_n;
  assign system_reset_n = sys_n;
  assign external_reset_pin_n_out = 1'b0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      external_reset_pin_n_oe_n <= 1'b0;
      drive_hist_reg            <= '1;
    end else begin
      external_reset_pin_n_oe_n <= sys_cond ? 1'b0 : sys_n;
      drive_hist_reg            <= {drive_hist_reg[PIN_HOLDOFF-2:0], ~sys_n};
    end
  end

  // Backup reset follows its own request only, untouched by power reset
  always_ff @(posedge aclk) begin
    backup_reset_n <= ~bkp_s;
  end

  // ==========================================================================
  // AXI4-Lite slave handshakes
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [31:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_write;
  logic        aw_full_next;
  logic        w_full_next;
  logic        bvalid_next;
  logic        rvalid_next;

  assign aw_hs        = s_axi_awvalid & s_axi_awready;
  assign w_hs         = s_axi_wvalid & s_axi_wready;
  assign ar_hs        = s_axi_arvalid & s_axi_arready;
  assign do_write     = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign aw_full_next = (aw_full_reg & ~do_write) | aw_hs;
  assign w_full_next  = (w_full_reg & ~do_write) | w_hs;
  assign bvalid_next  = (s_axi_bvalid & ~s_axi_bready) | do_write;
  assign rvalid_next  = (s_axi_rvalid & ~s_axi_rready) | ar_hs;

  // Write decode with byte strobes
  logic [31:0] wmask;
  logic [31:0] wd;
  logic        wr_rsc;
  logic        wr_pctl0;
  logic        wr_en;
  logic        wr_clr;
  logic        wr_hit;

  assign wmask    = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                     {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wd       = wdata_reg & wmask;
  assign wr_rsc   = do_write & (awaddr_reg == ADDR_RSC);
  assign wr_pctl0 = do_write & (awaddr_reg == ADDR_PCTL0);
  assign wr_en    = do_write & (awaddr_reg == ADDR_IRQ_EN);
  assign wr_clr   = do_write & (awaddr_reg == ADDR_IRQ_CLR);
  assign wr_hit   = wr_rsc | wr_pctl0 | wr_en | wr_clr |
                    (awaddr_reg == ADDR_PSTAT) | (awaddr_reg == ADDR_IRQ_STAT);

  // Channel flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      w_full_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
    end else begin
      aw_full_reg   <= aw_full_next;
      w_full_reg    <= w_full_next;
      s_axi_awready <= ~aw_full_next & ~bvalid_next;
      s_axi_wready  <= ~w_full_next & ~bvalid_next;
      s_axi_bvalid  <= bvalid_next;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid  <= rvalid_next;
    end
  end

  // Captured write address and data
  always_ff @(posedge aclk) begin
    if (aw_hs) begin
      awaddr_reg <= s_axi_awaddr;
    end
    if (w_hs) begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // ==========================================================================
  // Control registers, cleared by the power reset as well
  logic       ctl_rst;
  logic [2:0] lvt_sel_reg;
  logic       lvd_on_reg;
  logic [1:0] irq_en_reg;

  assign ctl_rst = ~aresetn | ~pwr_n;

  always_ff @(posedge aclk) begin
    if (ctl_rst) begin
      lvt_sel_reg <= LVT_RESET;
      lvd_on_reg  <= 1'b0;
      irq_en_reg  <= 2'h0;
      slow_rc_on  <= 1'b0;
    end else begin
      if (wr_pctl0 && wstrb_reg[0]) begin
        lvt_sel_reg <= wd[BIT_LVT_LSB+:3];
        lvd_on_reg  <= wd[BIT_LVD_ON];
      end
      if (wr_en && wstrb_reg[0]) begin
        irq_en_reg <= wd[1:0];
      end
      if (wr_rsc && wstrb_reg[0]) begin
        slow_rc_on <= wd[BIT_RC_ON];
      end
    end
  end

  // ==========================================================================
  // Reset cause flags {lp, wdt, sw, pwr, pin, bor}
  logic [5:0] flags_reg;
  logic [5:0] flag_set;
  logic       flag_clr;

  assign flag_set = {lp_s, wdt_s, sw_s, por_s, pin_req, bor_low};
  assign flag_clr = wr_rsc & wd[BIT_FLAG_CLR];

  // sticky, set wins over clear; only power-on restarts the record
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= 6'h00;
    end else if (por_s) begin
      flags_reg <= flag_set;
    end else begin
      flags_reg <= (flags_reg & ~{6{flag_clr}}) | flag_set;
    end
  end

  // ==========================================================================
  // Low voltage detector and interrupt line
  logic       lvd_cmp;
  logic       lvd_flag_next;
  logic       lvd_rise;
  logic       lvd_fall;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_stat_next;

  // code 111 selects the external pin comparison
  assign lvd_cmp = (lvt_sel_reg == LVT_EXT_PIN) ? lvd_pin_s : lvd_s[lvt_sel_reg];
  // flag high when below threshold, only while enabled
  assign lvd_flag_next = lvd_on_reg & ~lvd_cmp;
  assign lvd_rise      = lvd_flag_next & ~external_interrupt_unit_line16;
  assign lvd_fall      = ~lvd_flag_next & external_interrupt_unit_line16;
  // edge events, set wins over clear
  assign irq_stat_next = (irq_stat_reg & ~({2{wr_clr}} & wd[1:0])) |
                         {lvd_fall, lvd_rise};

  // Flag, sticky edge status and masked interrupt
  always_ff @(posedge aclk) begin
    if (ctl_rst) begin
      external_interrupt_unit_line16  <= 1'b0;
      irq_stat_reg <= 2'h0;
      irq          <= 1'b0;
    end else begin
      external_interrupt_unit_line16  <= lvd_flag_next;
      irq_stat_reg <= irq_stat_next;
      irq          <= |(irq_stat_next & irq_en_reg);
    end
  end

  // ==========================================================================
  // Read data selection
  logic [31:0] rsc_word;
  logic [31:0] rd_word;
  logic        rd_hit;

  assign rsc_word = {flags_reg[5], 1'b0, flags_reg[4:0], 1'b0, 22'h00_0000,
                     stb_s, slow_rc_on};
  assign rd_hit   = (s_axi_araddr == ADDR_RSC)      | (s_axi_araddr == ADDR_PCTL0) |
                    (s_axi_araddr == ADDR_PSTAT)    | (s_axi_araddr == ADDR_IRQ_STAT) |
                    (s_axi_araddr == ADDR_IRQ_EN)   | (s_axi_araddr == ADDR_IRQ_CLR);
  assign rd_word  = (s_axi_araddr == ADDR_RSC)      ? rsc_word :
                    (s_axi_araddr == ADDR_PCTL0)    ? {27'h0, lvd_on_reg, 1'b0, lvt_sel_reg} :
                    (s_axi_araddr == ADDR_PSTAT)    ? {31'h0, external_interrupt_unit_line16} :
                    (s_axi_araddr == ADDR_IRQ_STAT) ? {30'h0, irq_stat_reg} :
                    (s_axi_araddr == ADDR_IRQ_EN)   ? {30'h0, irq_en_reg} : 32'h0000_0000;

  // Read answer register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule : rstsup_top

// >>> test/reset_supervisor_lvd_tb_top.sv
// Purpose: Self-checking bench of the reset supervisor and detector
// Assumes: 25 MHz aclk, AXI4-Lite master in the bench
// Notes:   Far side comes from rstsup_partner
`timescale 1ns/1ns
module reset_supervisor_lvd_tb_top;
  import rstsup_pkg::*;
  // ==========================================================================
  logic aclk, aresetn, por_below, lvd_pin_above_ref, slow_rc_stable, press_n;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [4:0] bor_above;
  logic [2:0] brownout_threshold_code;
  logic [6:0] lvd_above;
  logic [11:0] supply_mv;
  logic watchdog_req, software_req, low_power_req, backup_req;
  logic external_reset_pin_n_in, external_reset_pin_n_out, external_reset_pin_n_oe_n;
  logic power_reset_n, system_reset_n, backup_reset_n, external_interrupt_unit_line16, slow_rc_on, irq;
  int failures, tests_run, cyc;

  rstsup_top dut (.*);
  rstsup_partner u_far (.supply_mv(supply_mv), .press_n(press_n),
    .pin_out(external_reset_pin_n_out), .oe_n(external_reset_pin_n_oe_n),
    .por_below(por_below), .bor_above(bor_above), .lvd_above(lvd_above),
    .pin_in(external_reset_pin_n_in));

  // Clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end
  // ==========================================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  // Bus write, response code left in rs
  task automatic axw(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axw
  // Bus read, data in rd and response in rs
  task automatic axr(input logic [31:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axr
  task automatic wait_up;
    while (power_reset_n !== 1'b1 || system_reset_n !== 1'b1) @(posedge aclk);
    repeat (8) @(posedge aclk);
  endtask : wait_up
  // ==========================================================================
  task automatic t_boot;
    wait_up();
    axr(ADDR_RSC);
    chk(rd & 32'hB800_0002, 32'h0800_0002);
    axw(ADDR_RSC, 32'h0100_0001);
    axr(ADDR_RSC);
    chk(rd, 32'h0000_0003);
    chk(slow_rc_on, 1'b1);
    axr(32'h4000_7014);
    chk({rd, rs}, {32'h0000_0000, RESP_SLVERR});
    axw(32'h4000_7018, 32'h0000_0001);
    chk(rs, RESP_SLVERR);
  endtask : t_boot
  // Watchdog, software, low-power and pin requests in turn, flags accumulate until cleared
  task automatic t_src;
    int bits [4] = '{BIT_WDT_FLAG, BIT_SW_FLAG, BIT_LP_FLAG, BIT_PIN_FLAG};
    logic [31:0] acc;
    int n;
    acc = 32'h0000_0003;
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      case (k)
        0: watchdog_req <= 1'b1;
        1: software_req <= 1'b1;
        2: low_power_req <= 1'b1;
        default: press_n <= 1'b0;
      endcase
      acc[bits[k]] = 1'b1;
      repeat (4) @(posedge aclk);
      chk(system_reset_n, 1'b0);
      {watchdog_req, software_req, low_power_req, press_n} <= 4'h1;
      n = 0;
      while (system_reset_n !== 1'b1 && n < 2000) begin
        @(posedge aclk);
        n++;
      end
      chk(32'(n >= 500), 32'h0000_0001);
      chk(power_reset_n, 1'b1);
      wait_up();
      axr(ADDR_RSC);
      chk(rd, acc);
    end
    axw(ADDR_RSC, 32'h0100_0001);
    axr(ADDR_RSC);
    chk(rd, 32'h0000_0003);
  endtask : t_src
  // Detector flag, interrupt edges, pin mode and disable
  task automatic t_lvd;
    axw(ADDR_PCTL0, 32'h0000_0013);
    axr(ADDR_PCTL0);
    chk(rd, 32'h0000_0013);
    axw(ADDR_IRQ_EN, 32'h0000_0001);
    supply_mv <= 12'h8CA; // 2250 mV, under threshold 3
    repeat (8) @(posedge aclk);
    chk({external_interrupt_unit_line16, irq}, 2'b11);
    axr(ADDR_PSTAT);
    chk(rd, 32'h0000_0001);
    axw(ADDR_IRQ_CLR, 32'h0000_0001);
    repeat (4) @(posedge aclk);
    chk(irq, 1'b0);
    supply_mv <= 12'hCE4;
    lvd_pin_above_ref <= 1'b0;
    repeat (8) @(posedge aclk);
    chk({external_interrupt_unit_line16, irq}, 2'b00);
    axw(ADDR_PCTL0, 32'h0000_0017);
    repeat (8) @(posedge aclk);
    chk(external_interrupt_unit_line16, 1'b1);
    axr(ADDR_IRQ_STAT);
    chk({rd, irq}, {32'h0000_0003, 1'b1});
    axw(ADDR_IRQ_EN, 32'h0000_0000);
    axw(ADDR_PCTL0, 32'h0000_0007);
    repeat (4) @(posedge aclk);
    chk({external_interrupt_unit_line16, irq}, 2'b00);
    axw(ADDR_IRQ_CLR, 32'h0000_0003);
    axr(ADDR_IRQ_STAT);
    chk(rd, 32'h0000_0000);
  endtask : t_lvd
  // Supply at 2450 mV against every brownout code
  task automatic t_bor;
    supply_mv <= 12'h992;
    for (int c = 0; c < 8; c++) begin
      @(posedge aclk);
      brownout_threshold_code <= 3'(c);
      repeat (8) @(posedge aclk);
      chk(power_reset_n, (c == 3 || c == 4) ? 1'b0 : 1'b1);
      if (c == 3 || c == 4) begin
        brownout_threshold_code <= 3'h0;
        wait_up();
        axr(ADDR_RSC);
        chk(rd[BIT_BOR_FLAG], 1'b1);
        axw(ADDR_RSC, 32'h0100_0001);
      end
    end
  endtask : t_bor
  // Ramp through the power-on level, then a backup-only reset
  task automatic t_por;
    axw(ADDR_PCTL0, 32'h0000_0015);
    @(posedge aclk);
    brownout_threshold_code <= 3'h2;
    supply_mv <= 12'h3E8;
    repeat (8) @(posedge aclk);
    chk({power_reset_n, backup_reset_n}, 2'b01);
    supply_mv <= 12'h76C;
    repeat (700) @(posedge aclk);
    chk(power_reset_n, 1'b0);
    supply_mv <= 12'hCE4;
    wait_up();
    axr(ADDR_RSC);
    chk(rd[BIT_PWR_FLAG], 1'b1);
    axr(ADDR_PCTL0);
    chk(rd, 32'h0000_0000);
    backup_req <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({backup_reset_n, power_reset_n, system_reset_n}, 3'b011);
    backup_req <= 1'b0;
    repeat (6) @(posedge aclk);
    chk(backup_reset_n, 1'b1);
  endtask : t_por
  // ==========================================================================
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    s_axi_wstrb = 4'hF;
    {watchdog_req, software_req, low_power_req, backup_req} = 4'h0;
    {press_n, lvd_pin_above_ref, slow_rc_stable} = 3'h7;
    brownout_threshold_code = 3'h0;
    supply_mv = 12'hCE4;
    {failures, tests_run, cyc} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_boot();
    $display("boot test done");
    t_src();
    $display("source test done");
    t_lvd();
    $display("detector test done");
    t_bor();
    $display("brownout test done");
    t_por();
    $display("power test done");
    conclude();
  end
endmodule : reset_supervisor_lvd_tb_top

// >>> test/rstsup_partner.sv
// Purpose: Far-side model: supply comparators and the open-drain reset pin
// Assumes: Supply given in millivolts; pin has an external pull-up
// Notes:   Threshold figures are plain defaults, set per board
`timescale 1ns/1ns
module rstsup_partner #(
  parameter int BOR_MV [5] = '{1600, 2100, 2300, 2600, 2900},
  parameter int POR_MV     = 1600,
  parameter int LVD_BASE   = 2000,
  parameter int LVD_STEP   = 100
) (
  // Stimulus from the bench
  input  wire logic [11:0] supply_mv,
  input  wire logic        press_n,
  // Pin drive from the device
  input  wire logic        pin_out,
  input  wire logic        oe_n,
  // Comparator results and pin level
  output logic             por_below,
  output logic [4:0]       bor_above,
  output logic [6:0]       lvd_above,
  output logic             pin_in
);
  // ==========================================================================
  // power-on comparator
  assign por_below = supply_mv < POR_MV;
  always_comb begin
    for (int i = 0; i < 5; i++) bor_above[i] = supply_mv > BOR_MV[i];
    for (int i = 0; i < 7; i++) lvd_above[i] = supply_mv > LVD_BASE + i * LVD_STEP;
  end
  // wired-low pin, pulled up when nobody drives
  assign pin_in = ((!oe_n && !pin_out) || !press_n) ? 1'b0 : 1'b1;
endmodule : rstsup_partner

// >>> test/rstsup_properties.sv
// Purpose: Port-level timing checks of the reset supervisor
// Assumes: One clock domain, synchronous active-low aresetn
// Notes:   Bound to rstsup_top after the module
`timescale 1ns/1ns
module rstsup_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // Requests and resets
  input wire logic por_below,
  input wire logic watchdog_req,
  input wire logic backup_req,
  input wire logic power_reset_n,
  input wire logic system_reset_n,
  input wire logic backup_reset_n,
  input wire logic external_reset_pin_n_oe_n
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Counts cycles of the current system reset pulse, saturating
  logic [10:0] low_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || system_reset_n) low_cnt_reg <= 11'h000;
    else if (!low_cnt_reg[10]) low_cnt_reg <= low_cnt_reg + 11'h001;
  end
  // ==========================================================================
  pin_drive_a: assert property (!system_reset_n && !$past(system_reset_n)
    |-> !external_reset_pin_n_oe_n) else $error("pin released during reset");
  stretch_min_a: assert property ($rose(system_reset_n) |-> low_cnt_reg >= 11'h1F4)
    else $error("reset pulse too short");
  por_reset_a: assert property (por_below |-> ##[1:4] !power_reset_n)
    else $error("power reset missing");
  wdg_reset_a: assert property (watchdog_req |-> ##[1:4] !system_reset_n)
    else $error("system reset missing");
  backup_reset_a: assert property (backup_req |-> ##[1:4] !backup_reset_n)
    else $error("backup reset missing");
  write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule : rstsup_properties

bind rstsup_top rstsup_properties u_props (.*);
